// File: hw/pmtr_pkg.sv
// Purpose: Shared constants and types for the program memory table read path
// Assumes: One clock cycle stands for one instruction cycle of the core
// Notes:   Pointer and memory widths are fixed for a 4K x 16 program memory
package pmtr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PM_AW    = 12;
  localparam int PM_DW    = 16;
  localparam int BYTE_W   = 8;
  localparam int PTRH_W   = 4;
  localparam int DM_AW    = 8;
  localparam int SECT_W   = 3;
  localparam int PCNT_W   = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing and reset values
  localparam logic [PM_AW-1:0]  LAST_PAGE_BASE = 12'hF00;
  localparam logic [PTRH_W-1:0] LAST_PAGE_HI   = 4'hF;
  localparam logic [BYTE_W-1:0] HI_STORED_MASK = 8'hFF;
  localparam logic [BYTE_W-1:0] HOLDER_RST     = 8'h00;
  localparam logic [SECT_W-1:0] BASE_SECTOR    = 3'h0;
  localparam logic [BYTE_W-1:0] PTR_STEP       = 8'h01;
  localparam logic [PM_DW-1:0]  WORD_ZERO      = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Serial programming frame: command bit, address, then data, MSB first
  localparam logic [PCNT_W-1:0] PCNT_ZERO      = 5'h00;
  localparam logic [PCNT_W-1:0] PCNT_ONE       = 5'h01;
  localparam logic [PCNT_W-1:0] PROG_ADDR_LAST = 5'h0B;
  localparam logic [PCNT_W-1:0] PROG_DATA_LAST = 5'h0F;
  localparam logic [PCNT_W-1:0] PROG_DATA_BITS = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Table read operations
  typedef enum logic [2:0] {
    PMTR_OP_TABLE_READ        = 3'h0,
    PMTR_OP_LAST_PAGE_READ    = 3'h1,
    PMTR_OP_INDEXED_READ      = 3'h2,
    PMTR_OP_INDEXED_LAST_PAGE = 3'h3,
    PMTR_OP_EXT_TABLE_READ    = 3'h4,
    PMTR_OP_EXT_LAST_PAGE     = 3'h5,
    PMTR_OP_EXT_INDEXED_READ  = 3'h6,
    PMTR_OP_EXT_INDEXED_LAST  = 3'h7
  } pmtr_op_t;

  typedef enum logic [1:0] {
    PMTR_ST_IDLE = 2'b01,
    PMTR_ST_XFER = 2'b10
  } pmtr_state_t;

  typedef enum logic [3:0] {
    PMTR_PS_CMD   = 4'b0001,
    PMTR_PS_ADDR  = 4'b0010,
    PMTR_PS_WDATA = 4'b0100,
    PMTR_PS_RDATA = 4'b1000
  } pmtr_pstate_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    pmtr_op_t            op;
    logic [BYTE_W-1:0]   ptr_lo;
    logic [PTRH_W-1:0]   ptr_hi;
    logic [DM_AW-1:0]    dm_addr;
    logic [SECT_W-1:0]   dm_sector;
  } pmtr_req_t;

  typedef struct packed {
    logic [SECT_W-1:0]   sector;
    logic [DM_AW-1:0]    addr;
    logic [BYTE_W-1:0]   data;
  } pmtr_dm_wr_t;

endpackage : pmtr_pkg

// File: hw/pmtr_pm_mem.sv
// Purpose: Program memory array with one write port and a registered read
// Assumes: Read data appear one clock after the read enable
// Notes:   The array has no reset; only the read register is cleared
`timescale 1ns/100ps
module pmtr_pm_mem (
  // Clock and reset
  input  wire logic                       clock_in,
  input  wire logic                       rst_in,
  // Write port
  input  wire logic                       we_in,
  input  wire logic [pmtr_pkg::PM_AW-1:0] waddr_in,
  input  wire logic [pmtr_pkg::PM_DW-1:0] wdata_in,
  // Read port
  input  wire logic                       re_in,
  input  wire logic [pmtr_pkg::PM_AW-1:0] raddr_in,
  output logic      [pmtr_pkg::PM_DW-1:0] rdata_out
);

  logic [pmtr_pkg::PM_DW-1:0] mem_q [0:(1<<pmtr_pkg::PM_AW)-1];
  logic [pmtr_pkg::PM_DW-1:0] rdata_q;

  always_ff @(posedge clock_in)
  begin
    if (we_in)
    begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rdata_q <= pmtr_pkg::WORD_ZERO;
    end
    else if (re_in)
    begin
      rdata_q <= mem_q[raddr_in];
    end
  end

  assign rdata_out = rdata_q;

endmodule : pmtr_pm_mem

// File: hw/pmtr_table_read.sv
// Purpose: Table read path of program memory plus its serial load port
// Assumes: Core issues a request only while busy_out is low
// Notes:   Serial programming expects the core to be idle meanwhile
`timescale 1ns/100ps
// Behaviour
// - Full address from low and high pointers
// - Low byte goes to operand data register
// - High byte goes to holding register
// - Unstored high byte bits read zero
// - Base ops sector zero, extended any sector
// - Every table instruction takes two cycles
// - Last-page ops ignore high pointer, page F00
// - Holding register readable and writable by software
// - Serial programming on one shared data pin
// - Each word is sixteen bits, two bytes
module pmtr_table_read (
  // Clock and reset
  input  wire logic                        clock_in,
  input  wire logic                        rst_in,
  // Core request
  input  wire logic                        req_valid_in,
  input  wire pmtr_pkg::pmtr_req_t         req_in,
  output logic                             busy_out,
  output logic                             hold_pc_out,
  output logic                             done_out,
  // Data memory write
  output logic                             dm_we_out,
  output pmtr_pkg::pmtr_dm_wr_t            dm_wr_out,
  // Low pointer update for indexed ops
  output logic                             ptr_lo_we_out,
  output logic      [pmtr_pkg::BYTE_W-1:0] ptr_lo_next_out,
  // Holding register access
  input  wire logic                        holder_we_in,
  input  wire logic [pmtr_pkg::BYTE_W-1:0] holder_wdata_in,
  output logic      [pmtr_pkg::BYTE_W-1:0] table_high_byte_holder_out,
  // Serial programming pins
  input  wire logic                        prog_mode_in,
  input  wire logic                        prog_serial_clock_pin_in,
  input  wire logic                        prog_serial_data_pin_in,
  output logic                             prog_serial_data_pin_out,
  output logic                             prog_serial_data_pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pmtr_pkg::pmtr_state_t             state_q;
  pmtr_pkg::pmtr_pstate_t            pstate_q;
  logic                              take;
  logic                              is_last;
  logic                              is_idx;
  logic                              is_ext;
  logic [pmtr_pkg::BYTE_W-1:0]       ptr_lo;
  logic [pmtr_pkg::PM_AW-1:0]        tab_addr;
  logic [pmtr_pkg::DM_AW-1:0]        dm_addr_q;
  logic [pmtr_pkg::SECT_W-1:0]       dm_sector_q;
  logic                              idx_q;
  logic [pmtr_pkg::BYTE_W-1:0]       ptr_next_q;
  logic [pmtr_pkg::BYTE_W-1:0]       holder_q;
  logic [pmtr_pkg::PM_DW-1:0]        mem_rdata;
  logic                              pck_q;
  logic                              prise;
  logic                              pfall;
  logic [pmtr_pkg::PCNT_W-1:0]       pcnt_q;
  logic                              pcmd_q;
  logic [pmtr_pkg::PM_AW-1:0]        paddr_q;
  logic [pmtr_pkg::PM_DW-1:0]        pshift_q;
  logic                              pload_q;
  logic                              pdout_q;
  logic                              prog_re;
  logic                              prog_we;
  logic [pmtr_pkg::PM_AW-1:0]        prog_raddr;

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode and address forming
  assign take    = (state_q == pmtr_pkg::PMTR_ST_IDLE) && req_valid_in;
  assign is_last = req_in.op[0];
  assign is_idx  = req_in.op[1];
  assign is_ext  = req_in.op[2];
  assign ptr_lo  = is_idx ? req_in.ptr_lo + pmtr_pkg::PTR_STEP
                          : req_in.ptr_lo;

  always_comb
  begin
    if (is_last)
    begin
      // High pointer plays no part here
      tab_addr = pmtr_pkg::LAST_PAGE_BASE | {{pmtr_pkg::PTRH_W{1'b0}}, ptr_lo};
    end
    else
    begin
      tab_addr = {req_in.ptr_hi, ptr_lo};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-cycle sequence: access in the first, transfer in the second
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_q <= pmtr_pkg::PMTR_ST_IDLE;
    end
    else
    begin
      case (state_q)
        pmtr_pkg::PMTR_ST_IDLE:
        begin
          if (take)
          begin
            state_q <= pmtr_pkg::PMTR_ST_XFER;
          end
        end
        pmtr_pkg::PMTR_ST_XFER:
        begin
          state_q <= pmtr_pkg::PMTR_ST_IDLE;
        end
        default:
        begin
          state_q <= pmtr_pkg::PMTR_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      dm_addr_q   <= '0;
      dm_sector_q <= pmtr_pkg::BASE_SECTOR;
      idx_q       <= 1'b0;
      ptr_next_q  <= '0;
    end
    else if (take)
    begin
      dm_addr_q   <= req_in.dm_addr;
      // Base ops reach sector zero only
      dm_sector_q <= is_ext ? req_in.dm_sector : pmtr_pkg::BASE_SECTOR;
      idx_q       <= is_idx;
      ptr_next_q  <= ptr_lo;
    end
  end

  // Fetch stalls for both cycles, then continues in order
  assign busy_out        = (state_q != pmtr_pkg::PMTR_ST_IDLE) || take;
  assign hold_pc_out     = busy_out;
  assign done_out        = (state_q == pmtr_pkg::PMTR_ST_XFER);
  assign dm_we_out       = done_out;
  assign ptr_lo_we_out   = done_out && idx_q;
  assign ptr_lo_next_out = ptr_next_q;

  // Read word is 16 bits: low byte out, high byte held
  assign dm_wr_out.sector = dm_sector_q;
  assign dm_wr_out.addr   = dm_addr_q;
  assign dm_wr_out.data   = mem_rdata[pmtr_pkg::BYTE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Holding register: table transfer wins over a software write
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      holder_q <= pmtr_pkg::HOLDER_RST;
    end
    else if (done_out)
    begin
      holder_q <= mem_rdata[pmtr_pkg::PM_DW-1:pmtr_pkg::BYTE_W]
                  & pmtr_pkg::HI_STORED_MASK;
    end
    else if (holder_we_in)
    begin
      holder_q <= holder_wdata_in;
    end
  end

  // Interrupt code may clobber this; software guards it
  assign table_high_byte_holder_out = holder_q;

  ////////////////////////////////////////////////////////////////////////////
  // Program memory
  pmtr_pm_mem u_mem (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .we_in     (prog_we),
    .waddr_in  (paddr_q),
    .wdata_in  ({pshift_q[pmtr_pkg::PM_DW-2:0], prog_serial_data_pin_in}),
    .re_in     (take || prog_re),
    .raddr_in  (take ? tab_addr : prog_raddr),
    .rdata_out (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Serial programming: sampled clock, one shared data pin
  assign prise = prog_serial_clock_pin_in && !pck_q;
  assign pfall = !prog_serial_clock_pin_in && pck_q;
  assign prog_re = prise && (pstate_q == pmtr_pkg::PMTR_PS_ADDR)
                   && (pcnt_q == pmtr_pkg::PROG_ADDR_LAST) && pcmd_q;
  assign prog_we = prise && (pstate_q == pmtr_pkg::PMTR_PS_WDATA)
                   && (pcnt_q == pmtr_pkg::PROG_DATA_LAST);
  // Last address bit is still on the pin when the read is issued
  assign prog_raddr = {paddr_q[pmtr_pkg::PM_AW-2:0], prog_serial_data_pin_in};

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pck_q   <= 1'b0;
      pload_q <= 1'b0;
    end
    else
    begin
      pck_q   <= prog_serial_clock_pin_in;
      pload_q <= prog_re;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in || !prog_mode_in)
    begin
      pstate_q <= pmtr_pkg::PMTR_PS_CMD;
      pcnt_q   <= pmtr_pkg::PCNT_ZERO;
      pcmd_q   <= 1'b0;
      paddr_q  <= '0;
      pshift_q <= pmtr_pkg::WORD_ZERO;
      pdout_q  <= 1'b0;
    end
    else if (pload_q)
    begin
      pshift_q <= mem_rdata;
    end
    else
    begin
      case (pstate_q)
        pmtr_pkg::PMTR_PS_CMD:
        begin
          if (prise)
          begin
            pcmd_q   <= prog_serial_data_pin_in;
            pcnt_q   <= pmtr_pkg::PCNT_ZERO;
            pstate_q <= pmtr_pkg::PMTR_PS_ADDR;
          end
        end
        pmtr_pkg::PMTR_PS_ADDR:
        begin
          if (prise)
          begin
            paddr_q <= {paddr_q[pmtr_pkg::PM_AW-2:0], prog_serial_data_pin_in};
            pcnt_q  <= pcnt_q + pmtr_pkg::PCNT_ONE;
            if (pcnt_q == pmtr_pkg::PROG_ADDR_LAST)
            begin
              pcnt_q   <= pmtr_pkg::PCNT_ZERO;
              pstate_q <= pcmd_q ? pmtr_pkg::PMTR_PS_RDATA
                                 : pmtr_pkg::PMTR_PS_WDATA;
            end
          end
        end
        pmtr_pkg::PMTR_PS_WDATA:
        begin
          if (prise)
          begin
            pshift_q <= {pshift_q[pmtr_pkg::PM_DW-2:0],
                         prog_serial_data_pin_in};
            pcnt_q   <= pcnt_q + pmtr_pkg::PCNT_ONE;
            if (pcnt_q == pmtr_pkg::PROG_DATA_LAST)
            begin
              pstate_q <= pmtr_pkg::PMTR_PS_CMD;
            end
          end
        end
        pmtr_pkg::PMTR_PS_RDATA:
        begin
          // Data change on falling edges so the programmer samples on rising
          if (pfall && (pcnt_q != pmtr_pkg::PROG_DATA_BITS))
          begin
            pdout_q  <= pshift_q[pmtr_pkg::PM_DW-1];
            pshift_q <= {pshift_q[pmtr_pkg::PM_DW-2:0], 1'b0};
            pcnt_q   <= pcnt_q + pmtr_pkg::PCNT_ONE;
          end
          else if (prise && (pcnt_q == pmtr_pkg::PROG_DATA_BITS))
          begin
            pstate_q <= pmtr_pkg::PMTR_PS_CMD;
          end
        end
        default:
        begin
          pstate_q <= pmtr_pkg::PMTR_PS_CMD;
        end
      endcase
    end
  end

  // Pin turns round only for the read-back phase
  assign prog_serial_data_pin_out    = pdout_q;
  assign prog_serial_data_pin_oe_out = prog_mode_in
                                       && (pstate_q == pmtr_pkg::PMTR_PS_RDATA);

endmodule : pmtr_table_read

// File: test/pmtr_table_read_chk.sv
// Purpose: Port-level checks of the table read path
// Assumes: One clock domain with a synchronous reset
// Notes:   Sees only the ports of the top module
`timescale 1ns/100ps
module pmtr_table_read_chk (
  // Clock and reset
  input wire logic                        clock_in,
  input wire logic                        rst_in,
  // Core side
  input wire logic                        req_valid_in,
  input wire pmtr_pkg::pmtr_req_t         req_in,
  input wire logic                        busy_out,
  input wire logic                        hold_pc_out,
  input wire logic                        done_out,
  input wire logic                        dm_we_out,
  input wire pmtr_pkg::pmtr_dm_wr_t       dm_wr_out,
  input wire logic                        ptr_lo_we_out,
  input wire logic [pmtr_pkg::BYTE_W-1:0] ptr_lo_next_out,
  // Holding register and serial port
  input wire logic                        holder_we_in,
  input wire logic [pmtr_pkg::BYTE_W-1:0] holder_wdata_in,
  input wire logic [pmtr_pkg::BYTE_W-1:0] table_high_byte_holder_out,
  input wire logic                        prog_mode_in,
  input wire logic                        prog_serial_data_pin_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic take_w;
  assign take_w = req_valid_in && busy_out && !done_out;
  sequence s_done;
    done_out && dm_we_out ##1 !done_out;
  endsequence
  sequence s_step;
    ptr_lo_we_out ##1 !ptr_lo_we_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_ANSWER: assert property (take_w |=> s_done)
    else $error("done pulse missing after take");
  AST_DONE_CAUSE: assert property (done_out |-> $past(take_w))
    else $error("done without a taken request");
  AST_BUSY_SPAN: assert property ((busy_out == (req_valid_in || done_out))
    && (hold_pc_out == busy_out))
    else $error("fetch hold outside the two cycles");
  AST_BASE_SECT: assert property (take_w && !req_in.op[2]
    |=> dm_wr_out.sector == pmtr_pkg::BASE_SECTOR)
    else $error("base op not in sector zero");
  AST_EXT_SECT: assert property (take_w && req_in.op[2]
    |=> dm_wr_out.sector == $past(req_in.dm_sector))
    else $error("extended op lost its sector");
  AST_DEST: assert property (take_w
    |=> dm_wr_out.addr == $past(req_in.dm_addr))
    else $error("wrong destination register");
  AST_INDEXED: assert property (take_w && req_in.op[1] |=> (ptr_lo_next_out
    == $past(req_in.ptr_lo) + pmtr_pkg::PTR_STEP) ##0 s_step)
    else $error("low pointer not advanced");
  AST_PLAIN: assert property (take_w && !req_in.op[1]
    |=> !ptr_lo_we_out)
    else $error("pointer written on plain op");
  AST_HOLDER_SW: assert property (holder_we_in && !done_out
    |=> table_high_byte_holder_out == $past(holder_wdata_in))
    else $error("software write of holder lost");
  AST_HOLDER_KEEP: assert property (!holder_we_in && !done_out
    |=> $stable(table_high_byte_holder_out))
    else $error("holder changed with no cause");
  AST_PROG_QUIET: assert property (prog_serial_data_pin_oe_out
    |-> prog_mode_in && $past(prog_mode_in))
    else $error("data pin driven outside programming");
endmodule : pmtr_table_read_chk

bind pmtr_table_read pmtr_table_read_chk chk (.clock_in, .rst_in,
  .req_valid_in, .req_in, .busy_out, .hold_pc_out, .done_out, .dm_we_out,
  .dm_wr_out, .ptr_lo_we_out, .ptr_lo_next_out, .holder_we_in,
  .holder_wdata_in, .table_high_byte_holder_out, .prog_mode_in,
  .prog_serial_data_pin_oe_out);

// File: test/pmtr_prog_model.sv
// Purpose: Serial programmer on the far side of the load port
// Assumes: Clock stands low between frames
// Notes:   Released data shows the inverse of its last value
`timescale 1ns/100ps
module pmtr_prog_model (
  // Pacing clock
  input  wire logic clock_in,
  // Shared data wire and programmer clock
  input  wire logic sda_in,
  output logic      sck_out,
  output logic      sda_out
);
  initial
  begin
    sck_out = 1'b0;
    sda_out = 1'b0;
  end
  // Four clocks a level keeps clear of the two-clock minimum
  task automatic phase(input logic lvl);
    repeat (4) @(negedge clock_in);
    sck_out = lvl;
  endtask : phase
  task automatic bit_out(input logic b);
    sda_out = b;
    phase(1'b1);
    phase(1'b0);
  endtask : bit_out
  task automatic head(input logic rd, input logic [pmtr_pkg::PM_AW-1:0] a);
    bit_out(rd);
    for (int k = pmtr_pkg::PM_AW - 1; k >= 0; k--)
      bit_out(a[k]);
  endtask : head
  task automatic write_word(input logic [pmtr_pkg::PM_AW-1:0] a,
                            input logic [pmtr_pkg::PM_DW-1:0] d);
    head(1'b0, a);
    for (int k = pmtr_pkg::PM_DW - 1; k >= 0; k--)
      bit_out(d[k]);
    sda_out = ~sda_out;
  endtask : write_word
  task automatic read_word(input  logic [pmtr_pkg::PM_AW-1:0] a,
                           output logic [pmtr_pkg::PM_DW-1:0] d);
    head(1'b1, a);
    sda_out = ~sda_out;
    for (int k = pmtr_pkg::PM_DW - 1; k >= 0; k--)
    begin
      repeat (4) @(negedge clock_in);
      d[k] = sda_in;
      sck_out = 1'b1;
      phase(1'b0);
    end
  endtask : read_word
endmodule : pmtr_prog_model

// File: test/pmtr_table_read_tb_top.sv
// Purpose: Self-checking bench for the table read path
// Assumes: Memory is loaded through the serial port first
// Notes:   Requests run back to back with refused ones in between
`timescale 1ns/100ps
module pmtr_table_read_tb_top;
  logic                        clock_in, rst_in, req_valid_in, holder_we_in;
  logic                        prog_mode_in, busy_out, hold_pc_out, done_out;
  logic                        dm_we_out, ptr_lo_we_out, sck, m_sda;
  logic                        d_sda, d_oe;
  wire                         sda_w;
  pmtr_pkg::pmtr_req_t         req_in;
  pmtr_pkg::pmtr_dm_wr_t       dm_wr_out;
  logic [pmtr_pkg::BYTE_W-1:0] holder_wdata_in, ptr_lo_next_out, holder;
  logic [pmtr_pkg::PM_DW-1:0]  mem [4096];
  logic [pmtr_pkg::PM_DW-1:0]  rd;
  logic [pmtr_pkg::PM_AW-1:0]  addrs [16];
  logic [31:0]                 seed;
  int                          miscompares, checks, i;
  assign sda_w = d_oe ? d_sda : m_sda;
  pmtr_table_read uut (.clock_in(clock_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .busy_out(busy_out),
    .hold_pc_out(hold_pc_out), .done_out(done_out), .dm_we_out(dm_we_out),
    .dm_wr_out(dm_wr_out), .ptr_lo_we_out(ptr_lo_we_out),
    .ptr_lo_next_out(ptr_lo_next_out), .holder_we_in(holder_we_in),
    .holder_wdata_in(holder_wdata_in), .table_high_byte_holder_out(holder),
    .prog_mode_in(prog_mode_in), .prog_serial_clock_pin_in(sck),
    .prog_serial_data_pin_in(sda_w), .prog_serial_data_pin_out(d_sda),
    .prog_serial_data_pin_oe_out(d_oe));
  pmtr_prog_model prog (.clock_in(clock_in), .sda_in(sda_w),
    .sck_out(sck), .sda_out(m_sda));
  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(input string n, input logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic test_done();
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // Entered at a falling edge; leaves the next request pending
  task automatic run_op(input logic [2:0] op, input logic last);
    pmtr_pkg::pmtr_req_t        r;
    logic [pmtr_pkg::PM_AW-1:0] a;
    seed = lfsr(seed);
    a = addrs[op[0] ? {1'b0, seed[2:0]} : seed[3:0]];
    r.op = pmtr_pkg::pmtr_op_t'(op);
    r.ptr_lo = a[7:0] - (op[1] ? pmtr_pkg::PTR_STEP : 8'h00);
    r.ptr_hi = op[0] ? seed[7:4] : a[11:8];
    r.dm_addr = seed[15:8];
    r.dm_sector = seed[18:16];
    req_valid_in = 1'b1;
    req_in = r;
    #1 cmp("busy take", 32'h3, 32'({busy_out, hold_pc_out}));
    @(negedge clock_in);
    cmp("dm_wr_out", 32'({op[2] ? r.dm_sector : pmtr_pkg::BASE_SECTOR,
      r.dm_addr, mem[a][7:0]}), 32'(dm_wr_out));
    cmp("strobes", 32'({3'h7, op[1]}),
      32'({done_out, dm_we_out, busy_out, ptr_lo_we_out}));
    if (op[1])
      cmp("ptr next", 32'(a[7:0]), 32'(ptr_lo_next_out));
    req_in = ~r;
    holder_we_in = seed[20];
    holder_wdata_in = seed[31:24];
    @(negedge clock_in);
    holder_we_in = 1'b0;
    cmp("holder", 32'(mem[a][15:8] & pmtr_pkg::HI_STORED_MASK),
      32'(holder));
    cmp("refused", 32'h0, 32'(done_out));
    if (last)
    begin
      req_valid_in = 1'b0;
      #1 cmp("fetch", 32'h0, 32'({busy_out, hold_pc_out}));
    end
  endtask : run_op
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hD20BDA2B;
    {rst_in, req_valid_in, holder_we_in, prog_mode_in} = 4'h8;
    req_in = '0;
    holder_wdata_in = 8'h00;
    repeat (5) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    cmp("holder reset", 32'(pmtr_pkg::HOLDER_RST), 32'(holder));
    prog_mode_in = 1'b1;
    for (i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      addrs[i] = {(i < 8) ? pmtr_pkg::LAST_PAGE_HI : seed[11:8],
                  seed[7:1], 1'b1};
      mem[addrs[i]] = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[31:16];
      prog.write_word(addrs[i], mem[addrs[i]]);
    end
    prog.read_word(addrs[2], rd);
    cmp("serial read", 32'(mem[addrs[2]]), 32'(rd));
    @(negedge clock_in);
    prog_mode_in = 1'b0;
    repeat (3) @(negedge clock_in);
    holder_we_in = 1'b1;
    holder_wdata_in = 8'hA5;
    @(negedge clock_in);
    holder_we_in = 1'b0;
    cmp("holder write", 32'h0000_00A5, 32'(holder));
    for (i = 0; i < 48; i++)
      run_op(3'(i % 8), i == 47);
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    test_done();
  end
endmodule : pmtr_table_read_tb_top
